// [verilog/eelc_map.vh]
`ifndef EELC_MAP_VH
`define EELC_MAP_VH

// line counts
`define EELC_NLINES      24
`define EELC_NEXT        16
`define EELC_NINT        8
`define EELC_NPIN        55
`define EELC_SEL_W       6

// register byte offsets
`define EELC_OFS_IMASK   8'h00
`define EELC_OFS_EMASK   8'h04
`define EELC_OFS_RISE    8'h08
`define EELC_OFS_FALL    8'h0C
`define EELC_OFS_SWTRG   8'h10
`define EELC_OFS_PEND    8'h14
`define EELC_OFS_SEL0    8'h18
`define EELC_OFS_SEL1    8'h1C
`define EELC_OFS_SEL2    8'h20
`define EELC_OFS_SEL3    8'h24

// select field layout: four 8-bit fields per word
`define EELC_SEL_FLD_W   8
`define EELC_SEL_PER_REG 4

// reset values
`define EELC_RST_IMASK   24'h00_0000
`define EELC_RST_EMASK   24'h00_0000
`define EELC_RST_RISE    24'h00_0000
`define EELC_RST_FALL    24'h00_0000
`define EELC_RST_PEND    24'h00_0000
`define EELC_RST_SEL     96'h0000_0000_0000_0000_0000_0000

`endif

// [verilog/eelc_line_sel.v]
`include "eelc_map.vh"

// picks one pin of the pool for each external line
module eelc_line_sel #(
	parameter NPIN  = `EELC_NPIN,
	parameter NOUT  = `EELC_NEXT,
	parameter SEL_W = `EELC_SEL_W
) (
	input  wire [NPIN-1:0]       pins_i,
	input  wire [NOUT*SEL_W-1:0] sel_i,
	output wire [NOUT-1:0]       lines_o
);

	genvar g;
	generate
		for (g = 0; g < NOUT; g = g + 1)
		begin : g_mux
			wire [SEL_W-1:0] idx;
			assign idx = sel_i[g*SEL_W +: SEL_W];
			// out-of-range select parks the line low instead of aliasing a pin
			assign lines_o[g] = (idx < NPIN) ? pins_i[idx] : 1'b0;
		end
	endgenerate

endmodule // eelc_line_sel

// [verilog/eelc_top.v]
// Notes on behaviour
// - 24 edge lines, each giving interrupt, event and wakeup requests.
// - per-line rising and falling enables select rising, falling or both edges.
// - per-line mask suppresses that line's request only.
// - pending register holds one bit per line for a detected selected edge.
// - external edges caught even when shorter than one clock period.
// - sixteen external lines chosen by selector from up to 55 pins.
// - a waiting edge on any unmasked line raises async_wake_o, but that output is registered on sys_clk.
`include "eelc_map.vh"

module eelc_top #(
	parameter NLINES = `EELC_NLINES,
	parameter NEXT   = `EELC_NEXT,
	parameter NINT   = `EELC_NINT,
	parameter NPIN   = `EELC_NPIN,
	parameter SEL_W  = `EELC_SEL_W
) (
	input  wire                sys_clk_i,
	input  wire                resetn_i,
	input  wire [7:0]          addr_i,
	input  wire [31:0]         wdata_i,
	input  wire                wr_i,
	input  wire                rd_i,
	output reg  [31:0]         rdata_o,
	input  wire [NPIN-1:0]     gpio_i,
	input  wire [NINT-1:0]     int_src_i,
	output reg  [NLINES-1:0]   line_irq_o,
	output reg                 irq_o,
	output reg  [NLINES-1:0]   evt_o,
	output reg                 wake_o,
	output reg                 async_wake_o
);

	// reset release
	reg                    rst_s1_q;
	reg                    rst_n_q;

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// software registers
	reg  [NLINES-1:0]      imask_q;
	reg  [NLINES-1:0]      emask_q;
	reg  [NLINES-1:0]      rise_q;
	reg  [NLINES-1:0]      fall_q;
	reg  [NLINES-1:0]      pend_q;
	reg  [NLINES-1:0]      pend_d;
	reg  [NEXT*SEL_W-1:0]  sel_q;

	wire                   wr_imask;
	wire                   wr_emask;
	wire                   wr_rise;
	wire                   wr_fall;
	wire                   wr_swtrg;
	wire                   wr_pend;
	wire [3:0]             wr_sel;

	assign wr_imask  = wr_i && (addr_i == `EELC_OFS_IMASK);
	assign wr_emask  = wr_i && (addr_i == `EELC_OFS_EMASK);
	assign wr_rise   = wr_i && (addr_i == `EELC_OFS_RISE);
	assign wr_fall   = wr_i && (addr_i == `EELC_OFS_FALL);
	assign wr_swtrg  = wr_i && (addr_i == `EELC_OFS_SWTRG);
	assign wr_pend   = wr_i && (addr_i == `EELC_OFS_PEND);
	assign wr_sel[0] = wr_i && (addr_i == `EELC_OFS_SEL0);
	assign wr_sel[1] = wr_i && (addr_i == `EELC_OFS_SEL1);
	assign wr_sel[2] = wr_i && (addr_i == `EELC_OFS_SEL2);
	assign wr_sel[3] = wr_i && (addr_i == `EELC_OFS_SEL3);

	always @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			imask_q <= `EELC_RST_IMASK;
			emask_q <= `EELC_RST_EMASK;
			rise_q  <= `EELC_RST_RISE;
			fall_q  <= `EELC_RST_FALL;
		end
		else
		begin
			if (wr_imask)
				imask_q <= wdata_i[NLINES-1:0];
			if (wr_emask)
				emask_q <= wdata_i[NLINES-1:0];
			if (wr_rise)
				rise_q <= wdata_i[NLINES-1:0];
			if (wr_fall)
				fall_q <= wdata_i[NLINES-1:0];
		end
	end

	// source selection for the external lines
	wire [NEXT-1:0]        ext_line;
	wire [NLINES-1:0]      src;
	wire [4*32-1:0]        sel_rd;

	// reset image of every select field, sliced per line below
	localparam [NEXT*SEL_W-1:0] RST_SEL = `EELC_RST_SEL;

	genvar s;
	generate
		for (s = 0; s < NEXT; s = s + 1)
		begin : g_sel
			localparam REG = s / `EELC_SEL_PER_REG;
			localparam FLD = (s % `EELC_SEL_PER_REG) * `EELC_SEL_FLD_W;

			always @(posedge sys_clk_i or negedge rst_n_q)
			begin
				if (!rst_n_q)
					sel_q[s*SEL_W +: SEL_W] <= RST_SEL[s*SEL_W +: SEL_W];
				else if (wr_sel[REG])
					sel_q[s*SEL_W +: SEL_W] <= wdata_i[FLD +: SEL_W];
			end

			assign sel_rd[REG*32 + FLD +: `EELC_SEL_FLD_W] =
				{{(`EELC_SEL_FLD_W-SEL_W){1'b0}}, sel_q[s*SEL_W +: SEL_W]};
		end
	endgenerate

	eelc_line_sel #(
		.NPIN  (NPIN),
		.NOUT  (NEXT),
		.SEL_W (SEL_W)
	) u_sel (
		.pins_i  (gpio_i),
		.sel_i   (sel_q),
		.lines_o (ext_line)
	);

	// lines 0..15 from pins, the rest from internal sources
	assign src = {int_src_i, ext_line};

	// edge capture
	wire [NLINES-1:0]      hit;
	wire [NLINES-1:0]      raw_diff;

	genvar g;
	generate
		for (g = 0; g < NLINES; g = g + 1)
		begin : g_cap
			reg rt_q;
			reg ft_q;
			reg rs1_q;
			reg rs2_q;
			reg rs3_q;
			reg fs1_q;
			reg fs2_q;
			reg fs3_q;

			// the source itself clocks a toggle, so a pulse far shorter than
			// sys_clk still flips state; enables are quasi-static, change them
			// only while the line is idle
			always @(posedge src[g] or negedge rst_n_q)
			begin
				if (!rst_n_q)
					rt_q <= 1'b0;
				else if (rise_q[g])
					rt_q <= ~rt_q;
			end

			always @(negedge src[g] or negedge rst_n_q)
			begin
				if (!rst_n_q)
					ft_q <= 1'b0;
				else if (fall_q[g])
					ft_q <= ~ft_q;
			end

			always @(posedge sys_clk_i or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					rs1_q <= 1'b0;
					rs2_q <= 1'b0;
					rs3_q <= 1'b0;
					fs1_q <= 1'b0;
					fs2_q <= 1'b0;
					fs3_q <= 1'b0;
				end
				else
				begin
					rs1_q <= rt_q;
					rs2_q <= rs1_q;
					rs3_q <= rs2_q;
					fs1_q <= ft_q;
					fs2_q <= fs1_q;
					fs3_q <= fs2_q;
				end
			end

			assign hit[g] = (rs2_q ^ rs3_q) | (fs2_q ^ fs3_q);
			// toggles out of step with the last seen copy: an edge is waiting
			// even while sys_clk is stopped
			assign raw_diff[g] = (rt_q ^ rs3_q) | (ft_q ^ fs3_q);
		end
	endgenerate

	// pending bits: a new edge in the clearing cycle wins
	always @*
	begin
		pend_d = pend_q;
		if (wr_pend)
			pend_d = pend_d & ~wdata_i[NLINES-1:0];
		pend_d = pend_d | hit;
		// trigger writes store nothing, they raise pending and an event pulse
		if (wr_swtrg)
			pend_d = pend_d | wdata_i[NLINES-1:0];
	end

	always @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
			pend_q <= `EELC_RST_PEND;
		else
			pend_q <= pend_d;
	end

	// requests
	wire [NLINES-1:0]      line_irq_d;
	wire [NLINES-1:0]      sw_hit;
	wire [NLINES-1:0]      evt_d;

	assign line_irq_d = pend_d & imask_q;
	assign sw_hit     = wr_swtrg ? wdata_i[NLINES-1:0] : {NLINES{1'b0}};
	assign evt_d      = (hit | sw_hit) & emask_q;

	always @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			line_irq_o   <= {NLINES{1'b0}};
			irq_o        <= 1'b0;
			evt_o        <= {NLINES{1'b0}};
			wake_o       <= 1'b0;
			async_wake_o <= 1'b0;
		end
		else
		begin
			line_irq_o <= line_irq_d;
			irq_o      <= |line_irq_d;
			evt_o      <= evt_d;
			// any unmasked line asks the power logic to restart the clock
			wake_o     <= (|line_irq_d) | (|evt_d);
			// sampled copy for the first cycle after the clock restarts
			async_wake_o <= |(raw_diff & (imask_q | emask_q));
		end
	end

	// read port: data stands in the cycle after the strobe
	reg  [31:0]            rdata_d;

	always @*
	begin
		rdata_d = 32'h0000_0000;
		case (addr_i)
			`EELC_OFS_IMASK:
				rdata_d[NLINES-1:0] = imask_q;
			`EELC_OFS_EMASK:
				rdata_d[NLINES-1:0] = emask_q;
			`EELC_OFS_RISE:
				rdata_d[NLINES-1:0] = rise_q;
			`EELC_OFS_FALL:
				rdata_d[NLINES-1:0] = fall_q;
			`EELC_OFS_PEND:
				rdata_d[NLINES-1:0] = pend_q;
			`EELC_OFS_SEL0:
				rdata_d = sel_rd[31:0];
			`EELC_OFS_SEL1:
				rdata_d = sel_rd[63:32];
			`EELC_OFS_SEL2:
				rdata_d = sel_rd[95:64];
			`EELC_OFS_SEL3:
				rdata_d = sel_rd[127:96];
			default:
				rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
			rdata_o <= 32'h0000_0000;
		else if (rd_i)
			rdata_o <= rdata_d;
		else
			// idle cycles read zero so a late sample never sees stale data
			rdata_o <= 32'h0000_0000;
	end

endmodule // eelc_top

// [dv/eelc_chk.sv]
module eelc_chk #(parameter NLINES = 24, parameter NINT = 8, parameter NPIN = 55) (
	input wire              sys_clk_i,
	input wire              resetn_i,
	input wire [7:0]        addr_i,
	input wire [31:0]       wdata_i,
	input wire              wr_i,
	input wire              rd_i,
	input wire [31:0]       rdata_o,
	input wire [NPIN-1:0]   gpio_i,
	input wire [NINT-1:0]   int_src_i,
	input wire [NLINES-1:0] line_irq_o,
	input wire              irq_o,
	input wire [NLINES-1:0] evt_o,
	input wire              wake_o,
	input wire              async_wake_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	a_irq_or: assert property (irq_o == |line_irq_o) else $error("irq not or of lines");
	a_rd_idle: assert property (!rd_i |=> rdata_o == 0) else $error("rdata without read");
	a_rd_hi: assert property (rd_i && addr_i < 8'h18 |=> rdata_o[31:24] == 0) else $error("rdata upper bits");
	a_sel_pad: assert property (rd_i && addr_i >= 8'h18 |=> (rdata_o & 32'hC0C0_C0C0) == 0) else $error("select pad bits");
	a_rd_unmap: assert property (rd_i && addr_i > 8'h24 |=> rdata_o == 0) else $error("unmapped read");
	a_swtrg_rd: assert property (rd_i && addr_i == 8'h10 |=> rdata_o == 0) else $error("trigger read");
	a_wake_irq: assert property (irq_o |-> wake_o) else $error("irq without wake");
	a_wake_evt: assert property (|evt_o |-> wake_o) else $error("event without wake");
	// a clear lands one edge after the write, a mask write two
	a_irq_hold: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2)) else $error("irq dropped");
	c_irq: cover property ($rose(irq_o));
	c_evt: cover property (|evt_o);
	c_rd: cover property (rd_i ##1 rdata_o != 0);
endmodule // eelc_chk

bind eelc_top eelc_chk #(.NLINES(NLINES), .NINT(NINT), .NPIN(NPIN)) u_chk (.*);

// [dv/eelc_disp_model.sv]
// dispatcher side: counts event pulses and interrupt entries
module eelc_disp_model (
	input wire        clk_i,
	input wire        irq_i,
	input wire [23:0] evt_i,
	input wire        wake_i,
	output int        evt_n,
	output int        irq_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic irq_q = 0;
	initial evt_n = 0;
	initial irq_n = 0;
	always @(posedge clk_i)
	begin
		evt_n <= evt_n + $countones(evt_i);
		irq_n <= irq_n + (irq_i && !irq_q && wake_i);
		irq_q <= irq_i;
	end
endmodule // eelc_disp_model

// [dv/eelc_top_tb.sv]
module eelc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [7:0] a = 0, is = 0;
	logic [31:0] wd = 0, rdat;
	logic [54:0] gp = 0;
	logic [23:0] li, ev;
	logic irq, wk, aw;
	int miscompares = 0, checks_done = 0, en, rn;
	always #12.5 clk = ~clk;
	eelc_top dut (.sys_clk_i(clk), .resetn_i(rst_n), .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdat), .gpio_i(gp), .int_src_i(is), .line_irq_o(li), .irq_o(irq), .evt_o(ev),
		.wake_o(wk), .async_wake_o(aw));
	eelc_disp_model u_m (.clk_i(clk), .irq_i(irq), .evt_i(ev), .wake_i(wk), .evt_n(en), .irq_n(rn));
	task chk(string n, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task wr_r(logic [7:0] ad, logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_r(logic [7:0] ad, logic [31:0] e);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk("rdata", e, rdat);
	endtask
	task waitn(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task t_rise;
		wr_r(8'h18, 32'h0000_0036);
		wr_r(8'h08, 32'h0000_0001);
		wr_r(8'h00, 32'h0000_0001);
		@(posedge clk);
		gp[54] <= 1;
		waitn(1);
		chk("async_wake", 1, aw);
		waitn(4);
		chk("async_wake", 0, aw);
		chk("line_irq", 32'h0000_0001, li);
		chk("irq", 1, irq);
		rd_r(8'h14, 32'h0000_0001);
		wr_r(8'h14, 32'h0000_0001);
		waitn(2);
		chk("irq", 0, irq);
		gp[54] <= 0;
	endtask
	task t_fall;
		wr_r(8'h18, 32'h0000_0336);
		wr_r(8'h0C, 32'h0000_0002);
		wr_r(8'h00, 32'h0000_0003);
		rd_r(8'h18, 32'h0000_0336);
		@(posedge clk);
		gp[3] <= 1;
		waitn(6);
		rd_r(8'h14, 32'h0000_0000);
		gp[3] <= 0;
		waitn(5);
		chk("line_irq", 32'h0000_0002, li);
		wr_r(8'h14, 32'h0000_0002);
	endtask
	task t_short;
		wr_r(8'h04, 32'h0001_0000);
		wr_r(8'h08, 32'h0001_0001);
		@(posedge clk);
		is[0] <= 1;
		#5 is[0] <= 0;
		waitn(6);
		chk("events", 1, en);
		chk("irq", 0, irq);
		rd_r(8'h14, 32'h0001_0000);
		wr_r(8'h14, 32'h0001_0000);
	endtask
	task t_sw;
		wr_r(8'h00, 32'h0080_0003);
		wr_r(8'h10, 32'h0080_0000);
		waitn(2);
		chk("line_irq", 32'h0080_0000, li);
		chk("wake", 1, wk);
		rd_r(8'h10, 0);
		rd_r(8'h44, 0);
		wr_r(8'h14, 32'h0080_0000);
		waitn(2);
		chk("irq", 0, irq);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		waitn(4);
		rd_r(8'h00, 0);
		rd_r(8'h14, 0);
		t_rise;
		t_fall;
		t_short;
		t_sw;
		chk("irq_entries", 3, rn);
		test_done;
	end
	// whole run is under a hundred cycles
	initial
	begin
		#20us;
		miscompares++;
		test_done;
	end
endmodule // eelc_top_tb
